//--- rtl/catx_card.sv
// Card-side answer-to-reset sender and T=0 command framer with APB registers
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "catx_defs.svh"

module catx_card
	import catx_pkg::*;
#(
	parameter int ETU_CLKS = `CATX_ETU_CLKS
) (
	input wire logic SYS_CLK_I,
	input wire logic NRST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	output logic IRQ_O,
	input wire logic LINK_PWR_I,
	input wire logic LINK_CLK_I,
	input wire logic LINK_RST_N_I,
	input wire logic LINK_IO_I,
	output logic LINK_IO_O,
	output logic LINK_IO_OE_N_O
);

	localparam int EW = $clog2(ETU_CLKS);
	localparam logic [55:0] HIST_BYTES = `CATX_HIST;

	// Fewer than four link clocks per bit leave no room for mid-bit sampling
	if (ETU_CLKS < 4) begin : g_etu_chk
		$error("ETU_CLKS below 4 cannot be timed");
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detection

	logic [3:0] sy1_reg;
	logic [3:0] sy2_reg;
	logic clk_prev_reg;
	logic io_prev_reg;
	logic rst_prev_reg;
	logic pwr_s;
	logic lrst_s;
	logic io_s;
	logic lk_rise;

	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			sy1_reg <= 4'h2;
			sy2_reg <= 4'h2;
			clk_prev_reg <= 1'b0;
			io_prev_reg <= 1'b1;
			rst_prev_reg <= 1'b0;
		end else begin
			sy1_reg <= {LINK_PWR_I, LINK_RST_N_I, LINK_IO_I, LINK_CLK_I};
			sy2_reg <= sy1_reg;
			clk_prev_reg <= sy2_reg[0];
			io_prev_reg <= sy2_reg[1];
			rst_prev_reg <= sy2_reg[2];
		end
	end

	assign pwr_s = sy2_reg[3];
	assign lrst_s = sy2_reg[2];
	assign io_s = sy2_reg[1];
	assign lk_rise = sy2_reg[0] & ~clk_prev_reg;

	////////////////////////////////////////////////////////////////////////////
	// Registers

	logic [5:0] ctrl_reg;
	logic [`CATX_IRQ_W-1:0] irq_reg;
	logic [`CATX_IRQ_W-1:0] mask_reg;
	logic [`CATX_IRQ_W-1:0] ev;
	logic [17:0] rsp_reg;
	logic [7:0] hdr_reg [0:4];
	logic [7:0] rxb_reg;
	logic [7:0] wptr_reg;
	logic [7:0] rsp_mem [0:`CATX_MAX_RESP-1];
	logic wr;
	logic go;
	logic app_req;
	logic mapped;
	logic inv;
	catx_atr_type mode;
	catx_card_type card_reg;
	catx_link_type lnk_reg;
	catx_ser_type ser_reg;

	assign wr = PSEL_I & PENABLE_I & PWRITE_I;
	assign go = wr && PADDR_I == `CATX_A_GO;
	assign app_req = wr && PADDR_I == `CATX_A_CTRL && PWDATA_I[`CATX_C_APPREQ];
	assign inv = ctrl_reg[`CATX_C_INV];
	assign mode = catx_atr_type'(ctrl_reg[`CATX_C_MODE +: 2]);
	assign PREADY_O = 1'b1;
	assign mapped = PADDR_I[1:0] == 2'b00 && PADDR_I <= `CATX_A_GO;
	assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;
	assign IRQ_O = |(irq_reg & mask_reg);

	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			ctrl_reg <= `CATX_CTRL_RST;
			mask_reg <= '0;
			rsp_reg <= '0;
		end else if (wr) begin
			unique case (PADDR_I)
				`CATX_A_CTRL: ctrl_reg <= PWDATA_I[5:0] & 6'h37;
				`CATX_A_MASK: mask_reg <= PWDATA_I[`CATX_IRQ_W-1:0];
				`CATX_A_RSP: begin
					rsp_reg <= PWDATA_I[17:0];
					if (PWDATA_I[8:0] > 9'(`CATX_MAX_RESP))
						rsp_reg[8:0] <= 9'(`CATX_MAX_RESP);
				end
				default: ;
			endcase
		end
	end

	// Sticky events: a set in the same cycle as its clear wins
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I)
			irq_reg <= '0;
		else if (wr && PADDR_I == `CATX_A_IRQ)
			irq_reg <= (irq_reg & ~PWDATA_I[`CATX_IRQ_W-1:0]) | ev;
		else
			irq_reg <= irq_reg | ev;
	end

	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I)
			wptr_reg <= '0;
		else if (go)
			wptr_reg <= '0;
		else if (wr && PADDR_I == `CATX_A_BUF)
			wptr_reg <= wptr_reg + 8'h01;
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (wr && PADDR_I == `CATX_A_BUF)
			rsp_mem[wptr_reg] <= PWDATA_I[7:0];
	end

	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I)
			PRDATA_O <= '0;
		else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
			unique case (PADDR_I)
				`CATX_A_CTRL: PRDATA_O <= {26'h0, ctrl_reg};
				`CATX_A_STAT: PRDATA_O <= {24'h0, 1'b0, lnk_reg, ser_reg, card_reg};
				`CATX_A_IRQ: PRDATA_O <= {27'h0, irq_reg};
				`CATX_A_MASK: PRDATA_O <= {27'h0, mask_reg};
				`CATX_A_HDR: PRDATA_O <= {hdr_reg[0], hdr_reg[1], hdr_reg[2], hdr_reg[3]};
				`CATX_A_HDR2: PRDATA_O <= {16'h0, rxb_reg, hdr_reg[4]};
				`CATX_A_RSP: PRDATA_O <= {14'h0, rsp_reg};
				`CATX_A_BUF: PRDATA_O <= {24'h0, wptr_reg};
				default: PRDATA_O <= '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Card operating states

	logic atr_end;

	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I)
			card_reg <= CARD_INACTIVE;
		else if (!pwr_s)
			card_reg <= CARD_INACTIVE;
		else begin
			unique case (card_reg)
				CARD_INACTIVE: if (atr_end)
					card_reg <= CARD_READY;
				CARD_READY, CARD_OPER: if (app_req)
					card_reg <= CARD_APPMGMT;
				CARD_APPMGMT: if (ctrl_reg[`CATX_C_PIN] && ctrl_reg[`CATX_C_SESS])
					card_reg <= CARD_OPER;
				else if (ctrl_reg[`CATX_C_PIN])
					card_reg <= CARD_READY;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Answer-to-reset table

	function automatic logic [7:0] atr_rom(input catx_atr_type m, input logic [4:0] i,
		input logic iv);
		logic [71:0] pre;
		int hs;
		int k;
		pre = '0;
		hs = 6;
		k = int'(i);
		unique case (m)
			ATR_DUAL: begin
				pre = {`CATX_FORMAT, `CATX_TA1_RATE, `CATX_TD1_T0, `CATX_TD_T1,
					`CATX_TA_IFSC, `CATX_TB_WAIT, `CATX_TD_GLOBAL, `CATX_TA_CLKSTOP, 8'h00};
				hs = 9;
			end
			ATR_SPEC: begin
				pre = {`CATX_FORMAT, `CATX_TA1_RATE, `CATX_TD1_T1, `CATX_TA2_SPECIFIC,
					`CATX_TD_T1, `CATX_TA_IFSC, `CATX_TB_WAIT, `CATX_TD_GLOBAL,
					`CATX_TA_CLKSTOP};
				hs = 10;
			end
			default: begin
				pre = {`CATX_FORMAT, `CATX_TA1_RATE, `CATX_TD1_T0, `CATX_TD_GLOBAL,
					`CATX_TA_CLKSTOP, 32'h0};
				hs = 6;
			end
		endcase
		if (k == 0)
			atr_rom = iv ? `CATX_TS_INVERSE : `CATX_TS_DIRECT;
		else if (k < hs)
			atr_rom = pre[79 - 8 * k -: 8];
		else if (k < hs + `CATX_HIST_LEN)
			atr_rom = HIST_BYTES[55 - 8 * (k - hs) -: 8];
		else
			atr_rom = 8'h00;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Character engine: start, eight data, parity, two guard times

	logic [EW-1:0] etu_reg;
	logic [3:0] bit_reg;
	logic [9:0] sh_reg;
	logic tx_go;
	logic [7:0] tx_byte;
	logic [7:0] tx_lvl;
	logic [7:0] rx_lvl;
	logic [7:0] rx_byte;
	logic etu_end;
	logic rx_done;
	logic rx_perr;

	assign etu_end = lk_rise && etu_reg == EW'(ETU_CLKS - 1);
	assign tx_lvl = inv ? ~{<<{tx_byte}} : tx_byte;
	// Start plus eight data bits are shifted in; the parity bit is on the line now
	assign rx_lvl = sh_reg[9:2];
	assign rx_byte = inv ? ~{<<{rx_lvl}} : rx_lvl;
	assign rx_done = ser_reg == SER_RX && etu_end && bit_reg == 4'd9;
	assign rx_perr = rx_done && ((^rx_lvl) ^ io_s ^ inv);
	assign tx_go = ser_reg == SER_IDLE && (lnk_reg == LNK_ATR || lnk_reg == LNK_DATA
		|| lnk_reg == LNK_SW1 || lnk_reg == LNK_SW2);

	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			ser_reg <= SER_IDLE;
			etu_reg <= '0;
			bit_reg <= '0;
			sh_reg <= 10'h3FF;
		end else if (!pwr_s || !lrst_s) begin
			ser_reg <= SER_IDLE;
			sh_reg <= 10'h3FF;
		end else begin
			unique case (ser_reg)
				SER_IDLE: begin
					etu_reg <= '0;
					bit_reg <= '0;
					if (tx_go) begin
						ser_reg <= SER_TX;
						sh_reg <= {(^tx_byte) ^ inv, tx_lvl, 1'b0};
					end else if (lnk_reg inside {LNK_HDR, LNK_WAIT} && io_prev_reg
						&& !io_s) begin
						ser_reg <= SER_RX;
						etu_reg <= EW'(ETU_CLKS / 2);
					end
				end
				SER_TX: if (lk_rise) begin
					etu_reg <= etu_end ? '0 : etu_reg + 1'b1;
					if (etu_end) begin
						sh_reg <= {1'b1, sh_reg[9:1]};
						bit_reg <= bit_reg + 4'd1;
						if (bit_reg == 4'd11)
							ser_reg <= SER_IDLE;
					end
				end
				SER_RX: if (lk_rise) begin
					etu_reg <= etu_end ? '0 : etu_reg + 1'b1;
					if (etu_end) begin
						sh_reg <= {io_s, sh_reg[9:1]};
						bit_reg <= bit_reg + 4'd1;
						if (bit_reg == 4'd9)
							ser_reg <= SER_IDLE;
					end
				end
				default: ser_reg <= SER_IDLE;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			LINK_IO_O <= 1'b1;
			LINK_IO_OE_N_O <= 1'b1;
		end else begin
			LINK_IO_O <= sh_reg[0];
			LINK_IO_OE_N_O <= !(ser_reg == SER_TX && bit_reg < 4'd10);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Exchange framing

	logic [4:0] idx_reg;
	logic [7:0] tck_reg;
	logic [8:0] cnt_reg;
	logic [8:0] lim;
	logic [4:0] atr_len;
	logic has_tck;
	logic warn;

	assign warn = rsp_reg[`CATX_R_WARN];
	assign has_tck = mode == ATR_DUAL || mode == ATR_SPEC;
	assign atr_len = mode == ATR_DUAL ? `CATX_LEN_DUAL : mode == ATR_SPEC ? `CATX_LEN_SPEC
		: `CATX_LEN_T0;
	assign atr_end = lnk_reg == LNK_ATR && tx_go && idx_reg == atr_len - 5'd1;
	assign lim = hdr_reg[4] == 8'h00 ? 9'(`CATX_MAX_RESP) : {1'b0, hdr_reg[4]};

	always_comb begin
		unique case (lnk_reg)
			LNK_ATR: tx_byte = (has_tck && idx_reg == atr_len - 5'd1) ? tck_reg
				: atr_rom(mode, idx_reg, inv);
			LNK_DATA: tx_byte = rsp_mem[cnt_reg[7:0]];
			LNK_SW1: tx_byte = warn ? `CATX_SW_WARN : `CATX_SW_OK1;
			LNK_SW2: tx_byte = warn ? rsp_reg[`CATX_R_QUAL +: 8] : `CATX_SW_OK2;
			default: tx_byte = 8'h00;
		endcase
	end

	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			lnk_reg <= LNK_OFF;
			idx_reg <= '0;
			tck_reg <= '0;
			cnt_reg <= '0;
		end else if (!pwr_s || !lrst_s) begin
			lnk_reg <= LNK_OFF;
		end else begin
			unique case (lnk_reg)
				LNK_OFF: if (!rst_prev_reg) begin
					lnk_reg <= LNK_ATR;
					idx_reg <= '0;
					tck_reg <= '0;
				end
				LNK_ATR: if (tx_go) begin
					idx_reg <= idx_reg + 5'd1;
					if (idx_reg != 5'd0)
						tck_reg <= tck_reg ^ tx_byte;
					if (atr_end) begin
						lnk_reg <= LNK_HDR;
						idx_reg <= '0;
					end
				end
				LNK_HDR: if (rx_done) begin
					idx_reg <= idx_reg + 5'd1;
					if (idx_reg == 5'd4)
						lnk_reg <= LNK_WAIT;
				end
				LNK_WAIT: if (go) begin
					cnt_reg <= '0;
					idx_reg <= '0;
					if (rsp_reg[8:0] == 9'd0)
						lnk_reg <= LNK_SW1;
					else begin
						lnk_reg <= LNK_DATA;
						idx_reg <= 5'd1;
					end
				end
				LNK_DATA: if (tx_go) begin
					cnt_reg <= cnt_reg + 9'd1;
					if (cnt_reg + 9'd1 >= rsp_reg[8:0] || cnt_reg + 9'd1 >= lim)
						lnk_reg <= LNK_SW1;
				end
				LNK_SW1: if (tx_go)
					lnk_reg <= LNK_SW2;
				LNK_SW2: if (tx_go) begin
					lnk_reg <= LNK_HDR;
					idx_reg <= '0;
				end
				default: lnk_reg <= LNK_OFF;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			hdr_reg <= '{default: 8'h00};
			rxb_reg <= '0;
		end else if (rx_done) begin
			if (lnk_reg == LNK_HDR)
				hdr_reg[idx_reg[2:0]] <= rx_byte;
			else
				rxb_reg <= rx_byte;
		end
	end

	always_comb begin
		ev = '0;
		ev[`CATX_I_HDR] = rx_done && lnk_reg == LNK_HDR && idx_reg == 5'd4;
		ev[`CATX_I_RXB] = rx_done && lnk_reg == LNK_WAIT;
		ev[`CATX_I_DONE] = tx_go && lnk_reg == LNK_SW2;
		ev[`CATX_I_ATR] = atr_end;
		ev[`CATX_I_PERR] = rx_perr;
	end

endmodule // catx_card

`default_nettype wire

//--- rtl/catx_defs.svh
// Constants for the card-side answer-to-reset and T=0 exchange block
// Contract
// - Inactive means powered off; leave on activation (left here only as the last answer character starts)
// - Application management entered anytime; left after PINs (entered here from ready or operation only)
// - Operation only after a session activation succeeded
// - Success ends response with status 90 00
// - Zero expected length returns all, up to 256
// - Warning ends returned data with 62 XX
// - First answer character is 3B or 3F
// - Format 97: TA1, TD1, seven historical bytes
// - TA1 95 encodes factors 512 and 16
// - TD 1F then TA 42: clock stop low
// - TD1 80 then TD2 B1 for both protocols
// - TA3 FE declares 254 byte information field
// - TA2 81 means fixed specific T=1 mode
// - Historical A0: select by identifier, directory present
// - Historical 00: no extended lengths, no channels
`ifndef CATX_DEFS_SVH
`define CATX_DEFS_SVH

`define CATX_A_CTRL 8'h00
`define CATX_A_STAT 8'h04
`define CATX_A_IRQ 8'h08
`define CATX_A_MASK 8'h0C
`define CATX_A_HDR 8'h10
`define CATX_A_HDR2 8'h14
`define CATX_A_RSP 8'h18
`define CATX_A_BUF 8'h1C
`define CATX_A_GO 8'h20

`define CATX_C_MODE 0
`define CATX_C_INV 2
`define CATX_C_APPREQ 3
`define CATX_C_PIN 4
`define CATX_C_SESS 5
`define CATX_CTRL_RST 6'h00
`define CATX_I_HDR 0
`define CATX_I_RXB 1
`define CATX_I_DONE 2
`define CATX_I_ATR 3
`define CATX_I_PERR 4
`define CATX_IRQ_W 5
`define CATX_R_WARN 9
`define CATX_R_QUAL 10

`define CATX_F_FACTOR 512
`define CATX_D_FACTOR 16
`define CATX_ETU_CLKS (`CATX_F_FACTOR / `CATX_D_FACTOR)
`define CATX_MAX_RESP 256

`define CATX_TS_DIRECT 8'h3B
`define CATX_TS_INVERSE 8'h3F
`define CATX_FORMAT 8'h97
`define CATX_TA1_RATE 8'h95
`define CATX_TD1_T0 8'h80
`define CATX_TD1_T1 8'h91
`define CATX_TD_GLOBAL 8'h1F
`define CATX_TA_CLKSTOP 8'h42
`define CATX_TD_T1 8'hB1
`define CATX_TA2_SPECIFIC 8'h81
`define CATX_TA_IFSC 8'hFE
`define CATX_TB_WAIT 8'h00
`define CATX_HIST 56'h8031A073BE2100
`define CATX_HIST_LEN 7
`define CATX_LEN_T0 5'd13
`define CATX_LEN_DUAL 5'd17
`define CATX_LEN_SPEC 5'd18
`define CATX_SW_OK1 8'h90
`define CATX_SW_OK2 8'h00
`define CATX_SW_WARN 8'h62

`endif

//--- rtl/catx_pkg.sv
// Types for the card-side answer-to-reset and T=0 exchange block
package catx_pkg;
	typedef enum logic [1:0] {CARD_INACTIVE, CARD_READY, CARD_APPMGMT, CARD_OPER} catx_card_type;
	typedef enum logic [2:0] {LNK_OFF, LNK_ATR, LNK_HDR, LNK_WAIT, LNK_DATA, LNK_SW1,
		LNK_SW2} catx_link_type;
	typedef enum logic [1:0] {SER_IDLE, SER_TX, SER_RX} catx_ser_type;
	typedef enum logic [1:0] {ATR_T0, ATR_DUAL, ATR_SPEC, ATR_RSVD} catx_atr_type;
endpackage

//--- rtl/placeholder_none.sv
// No logic here: the whole block lives in catx_card.sv

//--- tb/catx_card_tb.sv
// Testbench for the card block
`timescale 1ns/1ps
`default_nettype none
module catx_card_tb;
	logic sys_clk, nrst, psel, penable, pwrite, se;
	logic [7:0] paddr;
	logic [31:0] pwdata, rd;
	wire [31:0] prdata;
	wire pready, pslverr, irq, lpwr, lclk, lrst_n, lio, io_o, oe_n;
	int errors, n_tests;
	localparam logic [55:0] HIST = 56'h8031A073BE2100;
	logic [7:0] ctl [4] = '{8'h08, 8'h10, 8'h08, 8'h30};
	logic [1:0] st [4] = '{2'h2, 2'h1, 2'h2, 2'h3};
	always #12.5 sys_clk = ~sys_clk;
	catx_card #(.ETU_CLKS(4)) uut (.SYS_CLK_I(sys_clk), .NRST_I(nrst), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_O(irq),
		.LINK_PWR_I(lpwr), .LINK_CLK_I(lclk), .LINK_RST_N_I(lrst_n), .LINK_IO_I(lio),
		.LINK_IO_O(io_o), .LINK_IO_OE_N_O(oe_n));
	catx_term_model #(.ETU(4)) term (.card_io_i(io_o), .card_oe_n_i(oe_n), .pwr_o(lpwr),
		.lclk_o(lclk), .rst_n_o(lrst_n), .io_o(lio));
	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task results();
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task atr(input logic [1:0] m, input logic inv);
		logic [7:0] q [$];
		logic [7:0] b;
		logic [7:0] x;
		term.down();
		apb(1'b1, 8'h08, 32'h1F);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd[1:0], 2'h0);
		apb(1'b1, 8'h00, {29'h0, inv, m});
		term.up();
		q = {inv ? 8'h03 : 8'h3B, 8'h97, 8'h95};
		if (m == 2'h0)
			q = {q, 8'h80, 8'h1F, 8'h42};
		if (m == 2'h1)
			q = {q, 8'h80, 8'hB1, 8'hFE, 8'h00, 8'h1F, 8'h42};
		if (m == 2'h2)
			q = {q, 8'h91, 8'h81, 8'hB1, 8'hFE, 8'h00, 8'h1F, 8'h42};
		for (int i = 0; i < 7; i++)
			q.push_back(HIST[55 - 8 * i -: 8]);
		x = 8'h00;
		for (int i = 1; i < q.size(); i++)
			x ^= q[i];
		if (m != 2'h0)
			q.push_back(x);
		if (inv)
			q = q[0:0];
		foreach (q[i]) begin
			term.rx(b);
			chk(b, q[i]);
		end
		term.etu(inv ? 1 : 3);
		$display("answer mode %0d inverse %0d done", m, inv);
	endtask
	task cmd(input logic [7:0] p3, input logic [8:0] len, input logic w, input logic [7:0] ql);
		logic [7:0] h [5];
		logic [7:0] b;
		int e;
		h = '{8'hA0, 8'hB2, 8'h01, 8'h04, p3};
		foreach (h[i])
			term.tx(h[i]);
		term.etu(1);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd[0], 1'b1);
		apb(1'b1, 8'h08, 32'h1F);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'hA0B20104);
		apb(1'b0, 8'h14, 32'h0);
		chk(rd[7:0], p3);
		e = (p3 == 8'h00) ? 256 : p3;
		if (len < e)
			e = len;
		for (int i = 0; i < e; i++)
			apb(1'b1, 8'h1C, 32'(i + 17));
		apb(1'b1, 8'h18, {14'h0, ql, w, len});
		apb(1'b1, 8'h20, 32'h0);
		for (int i = 0; i < e; i++) begin
			term.rx(b);
			chk(b, 32'(i + 17));
		end
		term.rx(b);
		chk(b, w ? 8'h62 : 8'h90);
		term.rx(b);
		chk(b, w ? ql : 8'h00);
		$display("command length %0h done", p3);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		errors = 0;
		n_tests = 0;
		repeat (16) @(posedge sys_clk);
		nrst <= 1'b1;
		chk(irq, 1'b0);
		apb(1'b0, 8'h24, 32'h0);
		chk(se, 1'b1);
		chk(rd, 32'h0);
		atr(2'h1, 1'b0);
		atr(2'h2, 1'b0);
		atr(2'h0, 1'b1);
		atr(2'h0, 1'b0);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd[3], 1'b1);
		chk(irq, 1'b0);
		apb(1'b1, 8'h0C, 32'h08);
		@(posedge sys_clk);
		chk(irq, 1'b1);
		apb(1'b1, 8'h0C, 32'h00);
		@(posedge sys_clk);
		chk(irq, 1'b0);
		apb(1'b1, 8'h0C, 32'h08);
		@(posedge sys_clk);
		chk(irq, 1'b1);
		apb(1'b1, 8'h08, 32'h08);
		@(posedge sys_clk);
		chk(irq, 1'b0);
		$display("interrupt test done");
		apb(1'b0, 8'h04, 32'h0);
		chk(rd[1:0], 2'h1);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 8'h00, {24'h0, ctl[i]});
			apb(1'b0, 8'h04, 32'h0);
			chk(rd[1:0], st[i]);
		end
		$display("card state test done");
		cmd(8'h00, 9'd3, 1'b0, 8'h00);
		cmd(8'h02, 9'd5, 1'b1, 8'h5A);
		cmd(8'h00, 9'd0, 1'b0, 8'h00);
		results();
	end
	initial begin
		#2000000;
		errors++;
		results();
	end
endmodule // catx_card_tb
bind catx_card catx_checker #(.ETU_CLKS(ETU_CLKS)) chk_i (.SYS_CLK_I(SYS_CLK_I), .NRST_I(NRST_I),
	.PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
	.PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
	.IRQ_O(IRQ_O), .LINK_PWR_I(LINK_PWR_I), .LINK_CLK_I(LINK_CLK_I), .LINK_RST_N_I(LINK_RST_N_I),
	.LINK_IO_I(LINK_IO_I), .LINK_IO_O(LINK_IO_O), .LINK_IO_OE_N_O(LINK_IO_OE_N_O));
`default_nettype wire

//--- tb/catx_checker.sv
// Port-level assertions for the card block
`timescale 1ns/1ps
`default_nettype none
module catx_checker #(
	parameter int ETU_CLKS = 32,
	parameter int LINK_DIV = 8
) (
	input wire logic SYS_CLK_I,
	input wire logic NRST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	input wire logic IRQ_O,
	input wire logic LINK_PWR_I,
	input wire logic LINK_CLK_I,
	input wire logic LINK_RST_N_I,
	input wire logic LINK_IO_I,
	input wire logic LINK_IO_O,
	input wire logic LINK_IO_OE_N_O
);
	localparam int CHAR_CLKS = 10 * ETU_CLKS * LINK_DIV;
	int run_cnt;
	// Length of the current stretch with the card driving the line
	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I)
			run_cnt <= 0;
		else
			run_cnt <= LINK_IO_OE_N_O ? 0 : run_cnt + 1;
	end
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!NRST_I);
	////////////////////////////////////////////////////////////////////////////////
	a_pwr_off: assert property (!LINK_PWR_I [*6] |-> LINK_IO_OE_N_O)
		else $error("card drives line while unpowered");
	a_rst_hold: assert property (!LINK_RST_N_I [*6] |-> LINK_IO_OE_N_O)
		else $error("card drives line in link reset");
	a_start_auth: assert property ($fell(LINK_IO_OE_N_O) |->
		$past(LINK_PWR_I, 4) && $past(LINK_RST_N_I, 4))
		else $error("card drives line before activation");
	a_mask_quiet: assert property (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == 8'h0C
		&& PWDATA_I[4:0] == 5'h00 |=> !IRQ_O)
		else $error("interrupt high with all masked");
	a_err_unmapped: assert property (PSEL_I && PENABLE_I && (PADDR_I > 8'h20 || PADDR_I[1:0] != 2'h0)
		|-> PSLVERR_O && PRDATA_O == 32'h0)
		else $error("unmapped access not refused");
	a_ok_mapped: assert property (PSEL_I && PENABLE_I && PADDR_I <= 8'h20 && PADDR_I[1:0] == 2'h0
		|-> !PSLVERR_O && PREADY_O)
		else $error("mapped access refused");
	a_start_low: assert property ($fell(LINK_IO_OE_N_O) |-> !LINK_IO_O)
		else $error("character without low start bit");
	a_guard_idle: assert property ($rose(LINK_IO_OE_N_O) |-> LINK_IO_OE_N_O [*8])
		else $error("guard time cut short");
	// Start bit begins off the link clock grid, so it may be one link period short
	a_char_len: assert property ($rose(LINK_IO_OE_N_O) && LINK_PWR_I && LINK_RST_N_I
		|-> run_cnt >= CHAR_CLKS - LINK_DIV - 4 && run_cnt <= CHAR_CLKS + 4)
		else $error("character length wrong");
	c_char: cover property ($fell(LINK_IO_OE_N_O));
	c_irq: cover property ($rose(IRQ_O));
	c_refuse: cover property (PSLVERR_O);
endmodule // catx_checker
`default_nettype wire

//--- tb/catx_term_model.sv
// Terminal model: power, card clock, card reset and pulled-up I/O line
`timescale 1ns/1ps
`default_nettype none
module catx_term_model #(
	parameter int ETU = 4
) (
	input wire logic card_io_i,
	input wire logic card_oe_n_i,
	output logic pwr_o,
	output logic lclk_o,
	output logic rst_n_o,
	output wire logic io_o
);
	logic drv;
	initial begin
		pwr_o = 1'b0;
		lclk_o = 1'b0;
		rst_n_o = 1'b0;
		drv = 1'b1;
	end
	// Clock stands still while unpowered
	always begin
		#100;
		lclk_o = pwr_o ? ~lclk_o : 1'b0;
	end
	assign io_o = card_oe_n_i ? drv : card_io_i;
	task etu(input int n);
		repeat (n * ETU) @(posedge lclk_o);
	endtask
	task down();
		pwr_o = 1'b0;
		rst_n_o = 1'b0;
	endtask
	task up();
		pwr_o = 1'b1;
		etu(4);
		rst_n_o = 1'b1;
	endtask
	task rx(output logic [7:0] b);
		@(negedge io_o);
		repeat (ETU / 2) @(posedge lclk_o);
		for (int i = 0; i < 8; i++) begin
			etu(1);
			b[i] = io_o;
		end
		etu(1);
	endtask
	task tx(input logic [7:0] b);
		etu(3);
		drv = 1'b0;
		for (int i = 0; i < 8; i++) begin
			etu(1);
			drv = b[i];
		end
		etu(1);
		drv = ^b;
		etu(1);
		drv = 1'b1;
	endtask
endmodule // catx_term_model
`default_nettype wire
